// [bench/cvc_core_model.sv]
`timescale 1ns/1ps
// ****
// core side: takes presented exceptions
// ****
module cvc_core_model
  import cvc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire cvc_exc_t exc_out,
  output logic exc_ack
);
  logic [1:0] wait_reg;
  always_ff @(posedge clk) begin
    if (!rst_n || !exc_out.req || exc_ack) begin
      wait_reg <= 2'h0;
      exc_ack <= 1'b0;
    end else if (wait_reg == (slow ? 2'h3 : 2'h0)) begin
      exc_ack <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 2'h1;
    end
  end
endmodule : cvc_core_model

// [bench/cvc_irq_checker.sv]
`timescale 1ns/1ps
// ****
// port checker
// ****
module cvc_irq_checker
  import cvc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic exc_ack,
  input wire logic drop_to_user,
  input wire logic nmi_pin_select,
  input wire logic nmi_pin_n,
  input wire logic io_valid,
  input wire logic io_write,
  input wire logic [31:0] io_wdata,
  input wire logic [31:0] fast_gpio_port,
  input wire logic [31:0] prio_rdata,
  input wire logic [31:0] tick_calibration,
  input wire logic [23:0] ten_ms_calibration,
  input wire cvc_exc_t exc_out,
  input wire logic [5:0] stacked_vector,
  input wire logic nmi_req,
  input wire logic priv_level,
  input wire logic [3:0] sys_hprot
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_stack_vec:
  assert property (exc_ack && exc_out.req |=>
    stacked_vector == $past(exc_out.vector)) else $error("stack bad");
  chk_irq_vec:
  assert property (exc_out.req && exc_out.is_irq |->
    exc_out.vector == {1'b0, exc_out.irq} + 6'h10) else $error("vec bad");
  chk_unused_irq:
  assert property (exc_out.req && exc_out.is_irq |->
    IRQ_USED_MASK[exc_out.irq]) else $error("unused request taken");
  chk_entry_addr:
  assert property (exc_out.req |-> exc_out.addr ==
    {24'h00_0000, exc_out.vector, 2'b00}) else $error("addr bad");
  chk_calib_zero:
  assert property (tick_calibration == 0 && ten_ms_calibration == 0)
    else $error("calibration not zero");
  chk_nmi_source:
  assert property (nmi_req == (nmi_pin_select && !$past(nmi_pin_n, 2)))
    else $error("nmi bad");
  chk_io_write:
  assert property (io_valid && io_write |=>
    fast_gpio_port == $past(io_wdata)) else $error("io write bad");
  chk_user_drop:
  assert property (drop_to_user && !exc_ack |=> !priv_level)
    else $error("no user level");
  chk_bus_prot:
  assert property ($stable(priv_level) |-> sys_hprot ==
    (priv_level ? HPROT_DATA_PRIV : HPROT_DATA_USER)) else $error("prot");
  chk_prio_bits:
  assert property ((prio_rdata & ~PRIO_IMPL_MASK) == 0)
    else $error("prio bits");
  cover property (exc_ack && exc_out.vector == VEC_NMI);
  cover property (exc_ack && exc_out.vector == VEC_SYSTEM_TICK);
  cover property (exc_ack && exc_out.is_irq);
endmodule : cvc_irq_checker
bind cvc_core_irq_cfg cvc_irq_checker checker_i (.*);

// [bench/testbench.sv]
`timescale 1ns/1ps
// ****
// bench top
// ****
module testbench;
  import cvc_pkg::*;
  logic clk = 0, rst_n = 0, nmi_pin_n = 1, nmi_pin_select = 0, slow = 0;
  logic hard_fault_req = 0, supervisor_call_req = 0, exc_ack, nmi_req;
  logic pendable_service_req = 0, drop_to_user = 0, prio_wr = 0;
  logic tick_enable = 0, tick_clock_select = 0, io_valid = 0, io_write = 0;
  logic [31:0] irq_req = 0, irq_enable = 0, prio_wdata = 0, io_wdata = 0;
  logic [31:0] prio_rdata, tick_calibration, io_rdata, fast_gpio_port;
  logic [2:0] prio_idx = 0;
  logic [23:0] tick_reload = 0, tick_current, ten_ms_calibration;
  logic [5:0] stacked_vector;
  logic [3:0] sys_hprot;
  logic priv_level;
  cvc_exc_t exc_out;
  logic [31:0] pw [8];
  logic [5:0] sysv [3] = '{VEC_HARD_FAULT, VEC_SUPERVISOR_CALL,
    VEC_PENDABLE_SERVICE};
  int fail_count = 0, check_count = 0, seed = 55266, a, b, n, w;
  always #25 clk = ~clk;
  cvc_core_irq_cfg dut (.*);
  cvc_core_model core (.*);
  function automatic int pr(input int i);
    return pw[i / 4][8 * (i % 4) + 6 +: 2];
  endfunction : pr
  function automatic int pick();
    int i;
    do i = {$random(seed)} % 32; while (!IRQ_USED_MASK[i]);
    return i;
  endfunction : pick
  task chk(input logic [31:0] s, input logic [31:0] e, input string nm);
    check_count++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, s);
      fail_count++;
    end
  endtask : chk
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  task tmo;
    fail_count++;
    end_sim();
  endtask : tmo
  task cyc(input int k);
    repeat (k) @(posedge clk);
    @(negedge clk);
  endtask : cyc
  task period(input int e);
    logic [23:0] v;
    @(negedge clk);
    repeat (2) begin
      v = tick_current;
      n = 0;
      while (tick_current === v) begin
        @(negedge clk);
        if (++n > 40) tmo();
      end
    end
    chk(n, e, "tick step");
  endtask : period
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1;
    irq_enable <= '1;
    cyc(1);
    chk(priv_level, 1, "reset priv");
    chk(stacked_vector, 0, "stack");
    chk(tick_calibration, 0, "calib");
    chk(ten_ms_calibration, 0, "ten ms");
    for (int i = 0; i < 32; i++) begin
      @(posedge clk);
      irq_req <= 32'h1 << i;
      slow <= i[0];
      cyc(8);
      chk(exc_out.req, IRQ_USED_MASK[i], "req");
      if (IRQ_USED_MASK[i]) begin
        chk(exc_out.vector, i + 16, "vec");
        chk(exc_out.addr, (i + 16) * 4, "addr");
        chk(stacked_vector, i + 16, "stack");
      end
    end
    $display("request map done");
    for (int r = 0; r < 8; r++) begin
      @(posedge clk);
      w = $random(seed);
      pw[r] = w & PRIO_IMPL_MASK;
      prio_wr <= 1;
      prio_idx <= r;
      prio_wdata <= w;
      irq_req <= 0;
    end
    @(posedge clk);
    prio_wr <= 0;
    for (int r = 0; r < 8; r++) begin
      @(posedge clk);
      prio_idx <= r;
      cyc(2);
      chk(prio_rdata, pw[r], "prio reg");
    end
    for (int k = 0; k < 20; k++) begin
      a = pick();
      b = pick();
      @(posedge clk);
      irq_req <= (32'h1 << a) | (32'h1 << b);
      cyc(3);
      n = (pr(b) < pr(a) || (pr(b) == pr(a) && b < a)) ? b : a;
      chk(exc_out.irq, n, "winner");
      chk(exc_out.prio, pr(n), "prio");
    end
    @(posedge clk);
    irq_enable <= 0;
    cyc(2);
    chk(exc_out.req, 0, "masked");
    $display("priority done");
    @(posedge clk);
    nmi_pin_select <= 1;
    nmi_pin_n <= 0;
    cyc(5);
    chk(exc_out.vector, VEC_NMI, "nmi");
    chk(nmi_req, 1, "nmi pin");
    @(posedge clk);
    nmi_pin_select <= 0;
    cyc(2);
    chk(exc_out.req, 0, "nmi off");
    chk(nmi_req, 0, "nmi deselected");
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      nmi_pin_n <= 1;
      {hard_fault_req, supervisor_call_req, pendable_service_req} <=
        (k == 3) ? 3'h7 : 3'h4 >> k;
      cyc(3);
      chk(exc_out.vector, sysv[k % 3], "system vec");
    end
    $display("system exceptions done");
    @(posedge clk);
    {hard_fault_req, supervisor_call_req, pendable_service_req} <= 3'h0;
    tick_reload <= 24'h5;
    tick_clock_select <= 1;
    tick_enable <= 1;
    period(1);
    @(posedge clk);
    tick_clock_select <= 0;
    period(16);
    n = 0;
    while (!(exc_out.req === 1'b1 && exc_out.vector === VEC_SYSTEM_TICK)) begin
      @(negedge clk);
      if (++n > 200) tmo();
    end
    chk(exc_out.addr, 32'h0000_003c, "tick addr");
    $display("tick done");
    @(posedge clk);
    tick_enable <= 0;
    w = $random(seed);
    io_valid <= 1;
    io_write <= 1;
    io_wdata <= w;
    @(posedge clk);
    io_write <= 0;
    io_wdata <= ~w;
    @(posedge clk);
    io_valid <= 0;
    cyc(0);
    chk(io_rdata, w, "io read");
    chk(fast_gpio_port, w, "gpio");
    $display("io port done");
    cyc(4);
    @(posedge clk);
    drop_to_user <= 1;
    @(posedge clk);
    drop_to_user <= 0;
    cyc(2);
    chk(priv_level, 0, "user");
    chk(sys_hprot, HPROT_DATA_USER, "user prot");
    @(posedge clk);
    supervisor_call_req <= 1;
    cyc(6);
    chk(priv_level, 1, "priv");
    chk(sys_hprot, HPROT_DATA_PRIV, "priv prot");
    chk(stacked_vector, VEC_SUPERVISOR_CALL, "svc stack");
    $display("privilege done");
    end_sim();
  end
endmodule : testbench

// [src/cvc_core_irq_cfg.sv]
`timescale 1ns/1ps
// Overview of operation
// - four priority levels, each request has a two-bit priority field
// - request number is vector number minus 16; vector 16 is request 0
// - the stacked value on service is the taken exception's vector number
// - fixed system vectors 0,1,2,3,11,14; vectors 4-10,12,13 unused
// - system tick uses vector 15 at 0x3c; entries four bytes apart
// - requests 0-4 unused; 5-15 flash, voltage, pin, i2c, spi, uart, adc
// - request 16 comparator zero; 17-19 the three flex timers
// - tick clock select 1 means core clock, 0 means core clock / 16
// - ten millisecond calibration field always reads zero
// - non-maskable request only from active-low pin when mux selects it
// - dedicated 32-bit io port to fast gpio, one-cycle loads and stores
// - single 32-bit system bus interface for peripherals and memory
// - privileged and user execution levels both implemented
// - priority register index is request number divided by four
// - field lsb is 8 * (request mod 4) + 6, two bits wide
// - requests 20-31 timers, keyboards, lock, watchdog, can; 26 unused
module cvc_core_irq_cfg
  import cvc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [NUM_IRQ-1:0] irq_req,
  input wire logic [NUM_IRQ-1:0] irq_enable,
  input wire logic nmi_pin_n,
  input wire logic nmi_pin_select,
  input wire logic hard_fault_req,
  input wire logic supervisor_call_req,
  input wire logic pendable_service_req,
  input wire logic exc_ack,
  input wire logic drop_to_user,
  input wire logic prio_wr,
  input wire logic [2:0] prio_idx,
  input wire logic [31:0] prio_wdata,
  output logic [31:0] prio_rdata,
  input wire logic tick_enable,
  input wire logic tick_clock_select,
  input wire logic [TICK_WIDTH-1:0] tick_reload,
  output logic [TICK_WIDTH-1:0] tick_current,
  output logic [31:0] tick_calibration,
  output logic [23:0] ten_ms_calibration,
  output cvc_exc_t exc_out,
  output logic [5:0] stacked_vector,
  output logic nmi_req,
  output logic priv_level,
  output logic [3:0] sys_hprot,
  input wire logic io_valid,
  input wire logic io_write,
  input wire logic [31:0] io_wdata,
  output logic [31:0] io_rdata,
  output logic [31:0] fast_gpio_port
);

  // ****************************************************************
  // state
  // ****************************************************************
  cvc_state_t st_reg;
  cvc_state_t st_next;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic nmi_asserted(
    input logic pin_selected,
    input logic pin_sync_n
  );
    return pin_selected && !pin_sync_n;
  endfunction : nmi_asserted

  function automatic logic [3:0] hprot_for(input logic privileged);
    return privileged ? HPROT_DATA_PRIV : HPROT_DATA_USER;
  endfunction : hprot_for

  // ****************************************************************
  // working signals
  // ****************************************************************
  logic nmi_active;
  logic tick_step;
  logic tick_wrap;
  logic [NUM_IRQ-1:0] irq_live;
  logic best_valid;
  logic [1:0] best_prio;
  logic [4:0] best_irq;
  logic [1:0] field;
  cvc_exc_t sel;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_next = st_reg;
    field = 2'h0;
    sel = '0;

    // nmi pin synchroniser, second stage only is read
    st_next.nmi_sync = {st_reg.nmi_sync[0], nmi_pin_n};
    nmi_active = nmi_asserted(nmi_pin_select, st_reg.nmi_sync[1]);

    // priority register write, unimplemented bits read zero
    if (prio_wr) begin
      st_next.prio[prio_idx] = prio_wdata & PRIO_IMPL_MASK;
    end
    st_next.prio_rdata = st_reg.prio[prio_idx];

    // tick prescaler and counter
    tick_step = 1'b0;
    if (tick_enable) begin
      st_next.div_cnt = st_reg.div_cnt + 4'h1;
      tick_step = tick_clock_select ? 1'b1 :
                  (st_reg.div_cnt == TICK_DIV_LAST);
    end else begin
      st_next.div_cnt = 4'h0;
    end
    tick_wrap = 1'b0;
    if (tick_step) begin
      if (st_reg.tick_cnt == '0) begin
        st_next.tick_cnt = tick_reload;
      end else begin
        st_next.tick_cnt = st_reg.tick_cnt - 1'b1;
        tick_wrap = (st_reg.tick_cnt == 24'h00_0001);
      end
    end

    // unused request lines are masked off
    irq_live = irq_req & irq_enable;
    irq_live = irq_live & IRQ_USED_MASK;

    // lowest priority value wins, ties go to lowest request number
    best_valid = 1'b0;
    best_prio = 2'h3;
    best_irq = 5'h00;
    for (int i = 0; i < NUM_IRQ; i++) begin
      field = st_reg.prio[prio_reg_index(i)]
        [prio_field_lsb(i) +: PRIO_WIDTH];
      if (irq_live[i] && (!best_valid || field < best_prio)) begin
        best_valid = 1'b1;
        best_prio = field;
        best_irq = i[4:0];
      end
    end

    // fixed system exceptions first, then peripheral requests
    sel.req = 1'b1;
    if (nmi_active) begin
      sel.vector = VEC_NMI;
    end else if (hard_fault_req) begin
      sel.vector = VEC_HARD_FAULT;
    end else if (supervisor_call_req) begin
      sel.vector = VEC_SUPERVISOR_CALL;
    end else if (pendable_service_req) begin
      sel.vector = VEC_PENDABLE_SERVICE;
    end else if (st_reg.tick_pend) begin
      sel.vector = VEC_SYSTEM_TICK;
    end else if (best_valid) begin
      sel.is_irq = 1'b1;
      sel.irq = best_irq;
      sel.prio = best_prio;
      sel.vector = VEC_IRQ_BASE + {1'b0, best_irq};
    end else begin
      sel.req = 1'b0;
    end
    sel.addr = vector_addr(sel.vector);
    st_next.exc = sel;

    // exception taken by the core
    if (exc_ack && st_reg.exc.req) begin
      st_next.stacked_vector = st_reg.exc.vector;
      st_next.priv = 1'b1;
    end else if (drop_to_user) begin
      st_next.priv = 1'b0;
    end
    // set wins over the clear on the same cycle
    if (tick_wrap) begin
      st_next.tick_pend = 1'b1;
    end else if (exc_ack && st_reg.exc.req &&
                 st_reg.exc.vector == VEC_SYSTEM_TICK) begin
      st_next.tick_pend = 1'b0;
    end

    // single-cycle io port to fast gpio
    if (io_valid && io_write) begin
      st_next.fast_gpio = io_wdata;
    end
    if (io_valid && !io_write) begin
      st_next.io_rdata = st_reg.fast_gpio;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.prio <= {NUM_PRIO_REGS{PRIO_RESET}};
      st_reg.nmi_sync <= 2'h3;
      st_reg.priv <= 1'b1;
      st_reg.fast_gpio <= FAST_GPIO_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign prio_rdata = st_reg.prio_rdata;
  assign tick_current = st_reg.tick_cnt;
  assign tick_calibration = TICK_CALIB_VALUE;
  assign ten_ms_calibration = TICK_TEN_MS;
  assign exc_out = st_reg.exc;
  assign stacked_vector = st_reg.stacked_vector;
  assign nmi_req = nmi_asserted(nmi_pin_select, st_reg.nmi_sync[1]);
  assign priv_level = st_reg.priv;
  assign sys_hprot = hprot_for(st_reg.priv);
  assign io_rdata = st_reg.io_rdata;
  assign fast_gpio_port = st_reg.fast_gpio;

endmodule : cvc_core_irq_cfg

// [src/cvc_pkg.sv]
package cvc_pkg;

  // ****************************************************************
  // exception vector map
  // ****************************************************************
  localparam logic [5:0] VEC_INIT_SP = 6'h00;
  localparam logic [5:0] VEC_INIT_PC = 6'h01;
  localparam logic [5:0] VEC_NMI = 6'h02;
  localparam logic [5:0] VEC_HARD_FAULT = 6'h03;
  localparam logic [5:0] VEC_SUPERVISOR_CALL = 6'h0b;
  localparam logic [5:0] VEC_PENDABLE_SERVICE = 6'h0e;
  localparam logic [5:0] VEC_SYSTEM_TICK = 6'h0f;
  localparam logic [5:0] VEC_IRQ_BASE = 6'h10;
  localparam logic [31:0] VEC_TABLE_BASE = 32'h0000_0000;
  localparam logic [31:0] VEC_ENTRY_BYTES = 32'h0000_0004;
  localparam logic [31:0] TICK_ENTRY_ADDR = 32'h0000_003c;

  // ****************************************************************
  // request numbers
  // ****************************************************************
  localparam int NUM_IRQ = 32;
  localparam int NUM_PRIO_REGS = 8;
  localparam int IRQ_PER_REG = 4;
  localparam int PRIO_FIELD_STRIDE = 8;
  localparam int PRIO_FIELD_OFFSET = 6;
  localparam int PRIO_WIDTH = 2;
  localparam int PRIO_LEVELS = 4;
  // bit set for each request that has a source attached
  localparam logic [31:0] IRQ_USED_MASK = 32'hfbff_ffe0;
  localparam logic [4:0] IRQ_FLASH_CMD = 5'h05;
  localparam logic [4:0] IRQ_LOW_VOLTAGE = 5'h06;
  localparam logic [4:0] IRQ_EXT_PIN = 5'h07;
  localparam logic [4:0] IRQ_I2C_FIRST = 5'h08;
  localparam logic [4:0] IRQ_SPI_FIRST = 5'h0a;
  localparam logic [4:0] IRQ_UART_FIRST = 5'h0c;
  localparam logic [4:0] IRQ_CONVERTER_ZERO = 5'h0f;
  localparam logic [4:0] IRQ_COMPARATOR_ZERO = 5'h10;
  localparam logic [4:0] IRQ_FLEX_TIMER_FIRST = 5'h11;
  localparam logic [4:0] IRQ_RTC_OVERFLOW = 5'h14;
  localparam logic [4:0] IRQ_COMPARATOR_ONE = 5'h15;
  localparam logic [4:0] IRQ_PERIODIC_FIRST = 5'h16;
  localparam logic [4:0] IRQ_KEYBOARD_FIRST = 5'h18;
  localparam logic [4:0] IRQ_UNUSED_26 = 5'h1a;
  localparam logic [4:0] IRQ_CLOCK_LOCK = 5'h1b;
  localparam logic [4:0] IRQ_WATCHDOG = 5'h1c;
  localparam logic [4:0] IRQ_PULSE_TIMER = 5'h1d;
  localparam logic [4:0] IRQ_CAN_RX = 5'h1e;
  localparam logic [4:0] IRQ_CAN_TX_ERR_WAKE = 5'h1f;

  // ****************************************************************
  // priority registers, tick timer, io port
  // ****************************************************************
  localparam logic [31:0] PRIO_IMPL_MASK = 32'hc0c0_c0c0;
  localparam logic [31:0] PRIO_RESET = 32'h0000_0000;
  localparam logic [3:0] TICK_DIV_LAST = 4'hf;
  localparam logic [31:0] TICK_CALIB_VALUE = 32'h0000_0000;
  localparam logic [23:0] TICK_TEN_MS = 24'h00_0000;
  localparam int TICK_WIDTH = 24;
  localparam logic [31:0] FAST_GPIO_RESET = 32'h0000_0000;
  localparam logic [3:0] HPROT_DATA_USER = 4'h1;
  localparam logic [3:0] HPROT_DATA_PRIV = 4'h3;

  typedef struct packed {
    logic req;
    logic is_irq;
    logic [4:0] irq;
    logic [5:0] vector;
    logic [1:0] prio;
    logic [31:0] addr;
  } cvc_exc_t;

  typedef struct packed {
    logic [NUM_PRIO_REGS-1:0][31:0] prio;
    logic [1:0] nmi_sync;
    logic [3:0] div_cnt;
    logic [TICK_WIDTH-1:0] tick_cnt;
    logic tick_pend;
    cvc_exc_t exc;
    logic [5:0] stacked_vector;
    logic priv;
    logic [31:0] prio_rdata;
    logic [31:0] fast_gpio;
    logic [31:0] io_rdata;
  } cvc_state_t;

  function automatic int prio_reg_index(input int irq);
    return irq / IRQ_PER_REG;
  endfunction : prio_reg_index

  function automatic int prio_field_lsb(input int irq);
    return PRIO_FIELD_STRIDE * (irq % IRQ_PER_REG) + PRIO_FIELD_OFFSET;
  endfunction : prio_field_lsb

  function automatic logic [31:0] vector_addr(input logic [5:0] vec);
    return VEC_TABLE_BASE + {26'h000_0000, vec} * VEC_ENTRY_BYTES;
  endfunction : vector_addr

endpackage : cvc_pkg
